//--- src/ccf_pkg.sv
package ccf_pkg;

  // widths and counts
  localparam int unsigned CNT_W = 16;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_GR = 4;
  localparam int unsigned SYNC_IDX = 3;
  localparam int unsigned PSC_CNT_W = 3;

  // register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_MODE = 6'h04;
  localparam logic [5:0] OFS_COUNT = 6'h08;
  localparam logic [5:0] OFS_GRA = 6'h0c;
  localparam logic [5:0] OFS_GRB = 6'h10;
  localparam logic [5:0] OFS_GRC = 6'h14;
  localparam logic [5:0] OFS_GRD = 6'h18;
  localparam logic [5:0] OFS_FLAG = 6'h1c;
  localparam logic [5:0] OFS_ISTAT = 6'h20;
  localparam logic [5:0] OFS_IEN = 6'h24;
  localparam logic [5:0] OFS_ICLR = 6'h28;

  // field positions
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_PWM_BIT = 1;
  localparam int unsigned CTRL_PSC_LSB = 2;
  localparam int unsigned CTRL_PSC_W = 2;
  localparam int unsigned MODE_CAP_LSB = 0;
  localparam int unsigned MODE_TRG_LSB = 4;

  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hffff;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic [3:0] IEN_RST = 4'h0;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } ccf_bus_t;

endpackage : ccf_pkg

//--- src/ccf_sync.sv
`timescale 1ns/100ps
`default_nettype none

module ccf_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;

endmodule : ccf_sync

`default_nettype wire

//--- src/ccf_chan.sv
`timescale 1ns/100ps
`default_nettype none

module ccf_chan #(
  parameter bit IS_SYNC = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ccf_pkg::CNT_W-1:0] count,
  input wire logic pwm,
  input wire logic capMode,
  input wire logic trigCh9,
  input wire logic pinRise,
  input wire logic ch9Match,
  input wire logic wrEn,
  input wire logic [ccf_pkg::CNT_W-1:0] wrData,
  output logic [ccf_pkg::CNT_W-1:0] grVal,
  output logic setEvt
);

  logic [ccf_pkg::CNT_W-1:0] grVal_ff;
  logic [ccf_pkg::CNT_W-1:0] nxt_grVal;
  logic eqPrev_ff;
  logic nxt_eqPrev;
  logic capNow;
  logic capEn;
  logic matchRise;

  always_comb begin
    capNow = trigCh9 ? ch9Match : pinRise;
    capEn = !pwm && capMode;
    nxt_eqPrev = (count == grVal_ff);
    matchRise = nxt_eqPrev && !eqPrev_ff;
    nxt_grVal = grVal_ff;
    if (capEn && capNow) begin
      nxt_grVal = count;
    end else if (wrEn) begin
      nxt_grVal = wrData;
    end
    if (pwm) begin
      setEvt = IS_SYNC && matchRise;
    end else if (capMode) begin
      setEvt = capNow && !trigCh9;
    end else begin
      setEvt = matchRise;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      grVal_ff <= ccf_pkg::GR_RST;
      eqPrev_ff <= 1'b0;
    end else begin
      grVal_ff <= nxt_grVal;
      eqPrev_ff <= nxt_eqPrev;
    end
  end

  assign grVal = grVal_ff;

  a_pwm_no_set: assert property (@(posedge clk) disable iff (!rst_n)
    (pwm && !IS_SYNC) |-> !setEvt)
    else $error("flag event raised for a non-sync register in pwm mode");

  a_capture_set: assert property (@(posedge clk) disable iff (!rst_n)
    (!pwm && capMode && !trigCh9 && pinRise) |-> setEvt ##1 (grVal_ff == $past(count)))
    else $error("pin capture did not load register and raise event");

  a_ch9_skip: assert property (@(posedge clk) disable iff (!rst_n)
    (!pwm && capMode && trigCh9) |-> !setEvt)
    else $error("channel 9 triggered capture raised a flag event");

  a_compare_set: assert property (@(posedge clk) disable iff (!rst_n)
    (!pwm && !capMode && (count == grVal_ff) && !eqPrev_ff) |-> setEvt)
    else $error("compare match did not raise flag event");

  a_sync_set: assert property (@(posedge clk) disable iff (!rst_n)
    (pwm && IS_SYNC && (count == grVal_ff) && !$past(count == grVal_ff)) |-> setEvt)
    else $error("sync register match in pwm mode did not raise event");

endmodule : ccf_chan

`default_nettype wire

//--- src/ccf_top.sv
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module ccf_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ccf_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ccf_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [ccf_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [ccf_pkg::NUM_GR-1:0] capPin,
  input wire logic ch9Match,
  output logic ch3MatchFlagA,
  output logic ch3MatchFlagB,
  output logic ch3MatchFlagC,
  output logic ch3MatchFlagD,
  output logic irq
);

  localparam int unsigned N = ccf_pkg::NUM_GR;
  localparam int unsigned W = ccf_pkg::CNT_W;

  // merge the two low byte lanes into a 16-bit register
  function automatic logic [15:0] ccf_merge16(input logic [15:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : ccf_merge16

  // bus slave state
  ccf_pkg::ccf_bus_t busSt_ff;
  ccf_pkg::ccf_bus_t nxt_busSt;
  logic waitRq_ff;
  logic nxt_waitRq;
  logic [ccf_pkg::DATA_W-1:0] rdData_ff;
  logic [ccf_pkg::DATA_W-1:0] nxt_rdData;
  logic rdAcc;
  logic wrAcc;
  logic wrLow;

  // control state
  logic [3:0] ctrl_ff;
  logic [3:0] nxt_ctrl;
  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  logic [W-1:0] ch3FreeRunningCounter_ff;
  logic [W-1:0] nxt_ch3FreeRunningCounter;
  logic [ccf_pkg::PSC_CNT_W-1:0] pscCnt_ff;
  logic [ccf_pkg::PSC_CNT_W-1:0] nxt_pscCnt;
  logic [ccf_pkg::PSC_CNT_W-1:0] pscMask;
  logic cntTick;
  logic runEn;
  logic pwmEn;

  // flags and interrupt state
  logic [N-1:0] flags_ff;
  logic [N-1:0] nxt_flags;
  logic [N-1:0] armed_ff;
  logic [N-1:0] nxt_armed;
  logic [N-1:0] flagClr;
  logic [N-1:0] istat_ff;
  logic [N-1:0] nxt_istat;
  logic [N-1:0] ien_ff;
  logic [N-1:0] nxt_ien;
  logic irq_ff;
  logic nxt_irq;

  // capture inputs
  logic [N-1:0] capSync;
  logic [N-1:0] capPrev_ff;
  logic [N-1:0] pinRise;
  logic [N-1:0] setEvt;
  logic [N-1:0] grWrEn;
  logic [W-1:0] grVal [N];

  ccf_sync #(
    .WIDTH(N)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(capPin),
    .syncOut(capSync)
  );

  assign pinRise = capSync & ~capPrev_ff;
  assign runEn = ctrl_ff[ccf_pkg::CTRL_RUN_BIT];
  assign pwmEn = ctrl_ff[ccf_pkg::CTRL_PWM_BIT];

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_chan
      ccf_chan #(
        .IS_SYNC(g == ccf_pkg::SYNC_IDX)
      ) u_chan (
        .clk(clk),
        .rst_n(rst_n),
        .count(ch3FreeRunningCounter_ff),
        .pwm(pwmEn),
        .capMode(mode_ff[ccf_pkg::MODE_CAP_LSB + g]),
        .trigCh9(mode_ff[ccf_pkg::MODE_TRG_LSB + g]),
        .pinRise(pinRise[g]),
        .ch9Match(ch9Match),
        .wrEn(grWrEn[g]),
        .wrData(ccf_merge16(grVal[g], avs_writedata, avs_byteenable)),
        .grVal(grVal[g]),
        .setEvt(setEvt[g])
      );
      assign grWrEn[g] = wrLow && (avs_address == ccf_pkg::OFS_GRA + 6'(4 * g));
    end
  endgenerate

  // bus handshake: request seen in IDLE, answered one cycle later in ACK
  always_comb begin
    nxt_busSt = ccf_pkg::BUS_IDLE;
    if (busSt_ff == ccf_pkg::BUS_IDLE && (avs_read || avs_write)) begin
      nxt_busSt = ccf_pkg::BUS_ACK;
    end
    nxt_waitRq = (nxt_busSt != ccf_pkg::BUS_ACK);
    rdAcc = avs_read && (busSt_ff == ccf_pkg::BUS_ACK);
    wrAcc = avs_write && (busSt_ff == ccf_pkg::BUS_ACK);
    wrLow = wrAcc && (avs_byteenable[1:0] != 2'h0);
    nxt_rdData = rdData_ff;
    if (busSt_ff == ccf_pkg::BUS_IDLE && avs_read) begin
      unique case (avs_address)
        ccf_pkg::OFS_CTRL: nxt_rdData = 32'(ctrl_ff);
        ccf_pkg::OFS_MODE: nxt_rdData = 32'(mode_ff);
        ccf_pkg::OFS_COUNT: nxt_rdData = 32'(ch3FreeRunningCounter_ff);
        ccf_pkg::OFS_GRA: nxt_rdData = 32'(grVal[0]);
        ccf_pkg::OFS_GRB: nxt_rdData = 32'(grVal[1]);
        ccf_pkg::OFS_GRC: nxt_rdData = 32'(grVal[2]);
        ccf_pkg::OFS_GRD: nxt_rdData = 32'(grVal[3]);
        ccf_pkg::OFS_FLAG: nxt_rdData = 32'(flags_ff);
        ccf_pkg::OFS_ISTAT: nxt_rdData = 32'(istat_ff);
        ccf_pkg::OFS_IEN: nxt_rdData = 32'(ien_ff);
        default: nxt_rdData = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busSt_ff <= ccf_pkg::BUS_IDLE;
      waitRq_ff <= 1'b1;
      rdData_ff <= 32'h0000_0000;
    end else begin
      busSt_ff <= nxt_busSt;
      waitRq_ff <= nxt_waitRq;
      rdData_ff <= nxt_rdData;
    end
  end

  // control, prescaler and counter
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_mode = mode_ff;
    if (wrAcc && avs_byteenable[0] && avs_address == ccf_pkg::OFS_CTRL) begin
      nxt_ctrl = avs_writedata[3:0];
    end
    if (wrAcc && avs_byteenable[0] && avs_address == ccf_pkg::OFS_MODE) begin
      nxt_mode = avs_writedata[7:0];
    end
    pscMask = ccf_pkg::PSC_CNT_W'((4'h1 << ctrl_ff[ccf_pkg::CTRL_PSC_LSB +: ccf_pkg::CTRL_PSC_W]) - 4'h1);
    cntTick = ((pscCnt_ff & pscMask) == pscMask);
    nxt_pscCnt = pscCnt_ff + 3'h1;
    nxt_ch3FreeRunningCounter = ch3FreeRunningCounter_ff;
    if (wrLow && avs_address == ccf_pkg::OFS_COUNT) begin
      nxt_ch3FreeRunningCounter = ccf_merge16(ch3FreeRunningCounter_ff, avs_writedata, avs_byteenable);
    end else if (runEn && cntTick) begin
      nxt_ch3FreeRunningCounter = ch3FreeRunningCounter_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= ccf_pkg::CTRL_RST;
      mode_ff <= ccf_pkg::MODE_RST;
      pscCnt_ff <= 3'h0;
      ch3FreeRunningCounter_ff <= ccf_pkg::CNT_RST;
      capPrev_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      mode_ff <= nxt_mode;
      pscCnt_ff <= nxt_pscCnt;
      ch3FreeRunningCounter_ff <= nxt_ch3FreeRunningCounter;
      capPrev_ff <= capSync;
    end
  end

  // match flags with read-then-write-0 clearing, interrupt status
  always_comb begin
    nxt_armed = armed_ff;
    flagClr = '0;
    if (rdAcc && avs_address == ccf_pkg::OFS_FLAG) begin
      nxt_armed = armed_ff | rdData_ff[N-1:0];
    end
    if (wrAcc && avs_byteenable[0] && avs_address == ccf_pkg::OFS_FLAG) begin
      flagClr = armed_ff & ~avs_writedata[N-1:0];
      nxt_armed = armed_ff & ~flagClr;
    end
    nxt_flags = (flags_ff & ~flagClr) | setEvt;
    nxt_ien = ien_ff;
    if (wrAcc && avs_byteenable[0] && avs_address == ccf_pkg::OFS_IEN) begin
      nxt_ien = avs_writedata[N-1:0];
    end
    nxt_istat = istat_ff;
    if (wrAcc && avs_byteenable[0] && avs_address == ccf_pkg::OFS_ICLR) begin
      nxt_istat = istat_ff & ~avs_writedata[N-1:0];
    end
    nxt_istat = nxt_istat | setEvt;
    nxt_irq = |(nxt_istat & nxt_ien);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_ff <= ccf_pkg::FLAG_RST;
      armed_ff <= '0;
      istat_ff <= '0;
      ien_ff <= ccf_pkg::IEN_RST;
      irq_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      armed_ff <= nxt_armed;
      istat_ff <= nxt_istat;
      ien_ff <= nxt_ien;
      irq_ff <= nxt_irq;
    end
  end

  assign avs_readdata = rdData_ff;
  assign avs_waitrequest = waitRq_ff;
  assign ch3MatchFlagA = flags_ff[0];
  assign ch3MatchFlagB = flags_ff[1];
  assign ch3MatchFlagC = flags_ff[2];
  assign ch3MatchFlagD = flags_ff[3];
  assign irq = irq_ff;

  a_flag_reset_zero: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> (flags_ff == '0))
    else $error("match flags not zero after reset");

  a_clear_needs_read: assert property (@(posedge clk) disable iff (!rst_n)
    ((~flags_ff & $past(flags_ff) & ~$past(armed_ff)) == '0))
    else $error("flag cleared without a prior read as one");

  a_set_beats_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (setEvt != '0) |=> ((flags_ff & $past(setEvt)) == $past(setEvt)))
    else $error("flag event lost");

  a_flag_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !(wrAcc && avs_address == ccf_pkg::OFS_FLAG) |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff)))
    else $error("flag dropped without a clearing write");

  // read taken, one idle cycle, write raised, write taken one cycle later
  a_read_write_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (rdAcc && avs_address == ccf_pkg::OFS_FLAG && rdData_ff[0]) ##1 (!avs_read && !avs_write) [*1]
      ##1 (avs_write && !wrAcc)
      ##1 (wrAcc && avs_byteenable[0] && avs_address == ccf_pkg::OFS_FLAG && !avs_writedata[0] && !setEvt[0])
      |=> !flags_ff[0])
    else $error("read then write zero did not clear flag a");

  a_wait_answer: assert property (@(posedge clk) disable iff (!rst_n)
    (waitRq_ff && (avs_read || avs_write)) |=> !waitRq_ff ##1 waitRq_ff)
    else $error("waitrequest did not drop for exactly one cycle");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    irq_ff == |(istat_ff & ien_ff))
    else $error("interrupt output disagrees with enabled status");

  a_istat_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (setEvt != '0) |=> ((istat_ff & $past(setEvt)) == $past(setEvt)))
    else $error("status bit not set by a flag event");

  // only the synchronous register may raise an event while pwm is on
  a_pwm_abc_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    pwmEn |-> (setEvt[2:0] == 3'h0))
    else $error("pwm mode raised a flag event for registers a to c");

  a_flag_pins: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> !(ch3MatchFlagA || ch3MatchFlagB || ch3MatchFlagC || ch3MatchFlagD || irq))
    else $error("flag or interrupt pin high after reset");

endmodule : ccf_top

`default_nettype wire

//--- tb/ccf_top_test.sv
`timescale 1ns/100ps
`default_nettype none

module ccf_top_test;
  logic clk;
  logic rst_n;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] capPin;
  logic ch9Match;
  logic flagA, flagB, flagC, flagD, irq;
  logic [3:0] flags;
  logic [31:0] rd;
  int nFail;
  int testsRun;

  assign flags = {flagD, flagC, flagB, flagA};

  ccf_top ccf_top_inst (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .capPin(capPin), .ch9Match(ch9Match), .ch3MatchFlagA(flagA),
    .ch3MatchFlagB(flagB), .ch3MatchFlagC(flagC), .ch3MatchFlagD(flagD), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic reportAndStop;
    $display("compares %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : reportAndStop

  task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : checkWord

  task automatic checkFlags(input string what, input logic [3:0] exp, input logic expIrq);
    testsRun++;
    if (flags !== exp || irq !== expIrq) begin
      nFail++;
      $display("[FAIL] %s expected %h/%b seen %h/%b", what, exp, expIrq, flags, irq);
    end
  endtask : checkFlags

  // holds the request until waitrequest is sampled low, then idles one cycle
  task automatic busAccess(input logic isWr, input logic [5:0] a, input logic [31:0] d,
                           output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~isWr;
    avs_write <= isWr;
    // no cycle limit of its own; a wait that never sees waitrequest low is ended by the watchdog
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : busAccess

  task automatic busWrite(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    busAccess(1'b1, a, d, q);
  endtask : busWrite

  task automatic busRead(input logic [5:0] a, output logic [31:0] q);
    busAccess(1'b0, a, 32'h0, q);
  endtask : busRead

  task automatic waitFlag(input int i);
    int n;
    n = 0;
    while (flags[i] !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      nFail++;
      $display("[FAIL] flag %0d expected 1 seen timeout", i);
    end
    repeat (2) @(posedge clk);
  endtask : waitFlag

  task automatic clearFlag(input int i);
    busRead(ccf_pkg::OFS_FLAG, rd);
    busWrite(ccf_pkg::OFS_FLAG, 32'h0000000f ^ (32'h1 << i));
    repeat (2) @(posedge clk);
  endtask : clearFlag

  task automatic pulsePin(input int i);
    capPin[i] <= 1'b1;
    repeat (4) @(posedge clk);
    capPin[i] <= 1'b0;
  endtask : pulsePin

  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    $display("[FAIL] run length expected done seen watchdog");
    reportAndStop();
  end

  initial begin
    logic [5:0] gr;
    nFail = 0;
    testsRun = 0;
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    capPin = 4'h0;
    ch9Match = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    checkFlags("reset flags", 4'h0, 1'b0);
    busRead(ccf_pkg::OFS_FLAG, rd);
    checkWord("reset FLAG", 32'h0, rd);
    busRead(6'h3c, rd);
    checkWord("unmapped read", 32'h0, rd);
    // compare match on each general register in turn
    for (int i = 0; i < 4; i++) begin
      gr = ccf_pkg::OFS_GRA + 6'(i * 4);
      busWrite(ccf_pkg::OFS_CTRL, 32'h0);
      busWrite(ccf_pkg::OFS_MODE, 32'h0);
      busWrite(ccf_pkg::OFS_COUNT, 32'h0);
      busWrite(gr, 32'h0010);
      busWrite(ccf_pkg::OFS_CTRL, 32'h1 | 32'(i << 2));
      waitFlag(i);
      checkFlags("compare flag", 4'h1 << i, 1'b0);
      busWrite(ccf_pkg::OFS_FLAG, 32'h0);
      repeat (2) @(posedge clk);
      checkFlags("clear without read", 4'h1 << i, 1'b0);
      clearFlag(i);
      checkFlags("clear after read", 4'h0, 1'b0);
      busWrite(ccf_pkg::OFS_CTRL, 32'h0);
      busWrite(gr, 32'hffff);
    end
    // pin-triggered capture with the counter held
    busWrite(ccf_pkg::OFS_MODE, 32'h0f);
    for (int i = 0; i < 4; i++) begin
      gr = ccf_pkg::OFS_GRA + 6'(i * 4);
      busWrite(ccf_pkg::OFS_COUNT, 32'h1230 + 32'(i));
      pulsePin(i);
      waitFlag(i);
      checkFlags("capture flag", 4'h1 << i, 1'b0);
      busRead(gr, rd);
      checkWord("captured value", 32'h1230 + 32'(i), rd);
      clearFlag(i);
    end
    // channel 9 triggered capture loads but leaves flags clear
    busWrite(ccf_pkg::OFS_MODE, 32'hff);
    busWrite(ccf_pkg::OFS_COUNT, 32'h0abc);
    ch9Match <= 1'b1;
    @(posedge clk);
    ch9Match <= 1'b0;
    repeat (8) @(posedge clk);
    checkFlags("ch9 capture flags", 4'h0, 1'b0);
    busRead(ccf_pkg::OFS_GRD, rd);
    checkWord("ch9 capture value", 32'h0abc, rd);
    avs_byteenable <= 4'h1;
    busWrite(ccf_pkg::OFS_GRD, 32'h0000_5a5a);
    avs_byteenable <= 4'hf;
    busRead(ccf_pkg::OFS_GRD, rd);
    checkWord("low lane write", 32'h0a5a, rd);
    // pwm mode: only the synchronous register raises its flag
    busWrite(ccf_pkg::OFS_ICLR, 32'h0f);
    busWrite(ccf_pkg::OFS_IEN, 32'h0);
    busWrite(ccf_pkg::OFS_MODE, 32'h0);
    busWrite(ccf_pkg::OFS_COUNT, 32'h0);
    for (int i = 0; i < 4; i++) begin
      busWrite(ccf_pkg::OFS_GRA + 6'(i * 4), 32'h0020);
    end
    busWrite(ccf_pkg::OFS_CTRL, 32'h3);
    pulsePin(0);
    waitFlag(3);
    checkFlags("pwm flags", 4'h8, 1'b0);
    busRead(ccf_pkg::OFS_ISTAT, rd);
    checkWord("event status", 32'h8, rd);
    busWrite(ccf_pkg::OFS_IEN, 32'h8);
    repeat (2) @(posedge clk);
    checkFlags("irq enabled", 4'h8, 1'b1);
    busWrite(ccf_pkg::OFS_IEN, 32'h7);
    repeat (2) @(posedge clk);
    checkFlags("irq masked", 4'h8, 1'b0);
    busWrite(ccf_pkg::OFS_IEN, 32'h8);
    busWrite(ccf_pkg::OFS_ICLR, 32'h8);
    repeat (2) @(posedge clk);
    checkFlags("irq cleared", 4'h8, 1'b0);
    busRead(ccf_pkg::OFS_ICLR, rd);
    checkWord("clear reg reads", 32'h0, rd);
    clearFlag(3);
    checkFlags("pwm flag cleared", 4'h0, 1'b0);
    reportAndStop();
  end
endmodule : ccf_top_test

`default_nettype wire
